/* hdl/lsm_measure_ctrl.sv */
// measurement control registers and sequencing of the light sensor
// Notes on behaviour
// - writing 1 to flicker_detect_on starts flicker detection, 0 stops it.
// - writing 1 to ambient_measure_on runs ambient measurement, 0 stops it.
// - power_on_bit runs the oscillator; nothing measures without it.
// - writing power_on_bit 0 stops oscillator and clears both measure enables.
// - halt_after_count clears both enables after the set count, power stays on.
// - double drop lowers gain two steps on saturation when gain above one.
// - one_cycle_run does one measurement then asserts sleep_after_irq.
// - queue_light_status adds an ambient status record with the ambient data.
// - result_scale_bits leading zeros needed before scaled ambient value is used.
// - result_top_bit_select picks the top bit, 15 to 31, of the 32-bit ambient result; lower values give bit 15.
// - queue_end_tag appends an end record after each flicker measurement unless endless_flicker_runs is set.
// - queue_flicker_sum appends a checksum record after each flicker measurement.
// - queue_flicker_gain appends the gain record; host sets it under automatic gain.
// - all four registers return to their listed reset values.
// - endless_flicker_runs repeats flicker runs with no end records.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lsm_measure_ctrl #(
	parameter int GAIN_W = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [lsm_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	output logic osc_enable,
	output logic ambient_run,
	output logic flicker_run,
	output logic sleep_after_irq,
	input wire logic ambient_done,
	input wire logic flicker_done,
	input wire logic [31:0] ambient_raw,
	input wire logic [15:0] flicker_sum,
	input wire logic agc_down,
	input wire logic agc_sat,
	input wire logic agc_up,
	output logic [GAIN_W-1:0] gain_step,
	output logic [15:0] ambient_data,
	output logic rec_valid,
	input wire logic rec_ready,
	output lsm_pkg::lsm_rec_t rec
);
	logic [7:0] enable;
	logic [7:0] mode_first;
	logic [7:0] mode_second;
	logic [7:0] run_ctrl;
	logic [7:0] next_enable;
	logic [lsm_pkg::LIMIT_W-1:0] iter_count;
	logic [15:0] sum_hold;
	logic amb_scaled;
	logic [15:0] scale_data;
	logic scale_flag;
	logic [lsm_pkg::REC_KINDS-1:0] pending;
	logic [lsm_pkg::REC_KINDS-1:0] rec_set;
	logic [lsm_pkg::REC_KINDS-1:0] rec_clr;
	logic [2:0] cur_kind;
	lsm_pkg::lsm_emit_t emit_state;
	logic setup;
	logic access;
	logic hit;
	logic wr_lane;
	logic wr_enable;
	logic wr_first;
	logic wr_second;
	logic wr_run;
	logic [31:0] rd_value;
	logic amb_hit;
	logic flick_hit;
	logic endless;
	logic counted;
	logic halt_now;

	function automatic logic at(input logic [lsm_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
		return a == lsm_pkg::byte_addr(idx);
	endfunction : at

	// zero-wait slave: read data is captured in the setup cycle
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign pready = 1'b1;
	assign wr_lane = access && pwrite && pstrb[0];
	assign wr_enable = wr_lane && at(paddr, lsm_pkg::IDX_ENABLE);
	assign wr_first = wr_lane && at(paddr, lsm_pkg::IDX_MODE_FIRST);
	assign wr_second = wr_lane && at(paddr, lsm_pkg::IDX_MODE_SECOND);
	assign wr_run = wr_lane && at(paddr, lsm_pkg::IDX_RUN_CTRL);

	always_comb begin
		hit = 1'b1;
		rd_value = 32'h0;
		if (at(paddr, lsm_pkg::IDX_ENABLE)) begin
			rd_value = {24'h0, enable & lsm_pkg::ENABLE_MASK};
		end else if (at(paddr, lsm_pkg::IDX_MODE_FIRST)) begin
			rd_value = {24'h0, mode_first};
		end else if (at(paddr, lsm_pkg::IDX_MODE_SECOND)) begin
			rd_value = {24'h0, mode_second};
		end else if (at(paddr, lsm_pkg::IDX_RUN_CTRL)) begin
			rd_value = {24'h0, run_ctrl};
		end else if (at(paddr, lsm_pkg::IDX_STATUS)) begin
			rd_value[lsm_pkg::ST_GAIN_LSB +: GAIN_W] = gain_step;
			rd_value[lsm_pkg::ST_SLEEP] = sleep_after_irq;
			rd_value[lsm_pkg::ST_OSC] = osc_enable;
			rd_value[lsm_pkg::ST_SCALED] = amb_scaled;
		end else if (at(paddr, lsm_pkg::IDX_AMB_DATA)) begin
			rd_value = {16'h0, ambient_data};
		end else begin
			hit = 1'b0;
		end
	end

	assign pslverr = access && !hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (setup && !pwrite) begin
			prdata <= rd_value;
		end
	end

	// clearing power also drops both measure enables; reserved bits never stored
	assign next_enable = pwdata[lsm_pkg::EN_POWER] ? (pwdata[7:0] & lsm_pkg::ENABLE_MASK) : 8'h00;

	// a host write wins over a halt in the same cycle, since it is the newer intent
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable <= lsm_pkg::ENABLE_RST;
		end else if (wr_enable) begin
			enable <= next_enable;
		end else if (halt_now) begin
			enable <= enable & lsm_pkg::HALT_KEEP;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_first <= lsm_pkg::MODE_FIRST_RST;
			mode_second <= lsm_pkg::MODE_SECOND_RST;
			run_ctrl <= lsm_pkg::RUN_CTRL_RST;
		end else begin
			if (wr_first) begin
				mode_first <= pwdata[7:0];
			end
			if (wr_second) begin
				mode_second <= pwdata[7:0];
			end
			if (wr_run) begin
				run_ctrl <= pwdata[7:0];
			end
		end
	end

	assign osc_enable = enable[lsm_pkg::EN_POWER];
	assign ambient_run = osc_enable && enable[lsm_pkg::EN_AMBIENT] && !sleep_after_irq;
	assign flicker_run = osc_enable && enable[lsm_pkg::EN_FLICKER] && !sleep_after_irq;
	assign amb_hit = ambient_done && ambient_run;
	assign flick_hit = flicker_done && flicker_run;
	assign endless = run_ctrl[lsm_pkg::RC_ENDLESS];

	// endless flicker runs never count toward the halt
	assign counted = amb_hit || (flick_hit && !endless);
	assign halt_now = mode_first[lsm_pkg::M1_HALT] && counted
		&& (iter_count == run_ctrl[lsm_pkg::RC_LIMIT_LSB +: lsm_pkg::LIMIT_W]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			iter_count <= '0;
		end else if (wr_enable) begin
			iter_count <= '0;
		end else if (counted && !halt_now) begin
			iter_count <= iter_count + 1'b1;
		end
	end

	// sleep holds until the host writes the enable register again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_after_irq <= 1'b0;
		end else if (mode_first[lsm_pkg::M1_SINGLE] && (amb_hit || flick_hit)) begin
			sleep_after_irq <= 1'b1;
		end else if (wr_enable) begin
			sleep_after_irq <= 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gain_step <= GAIN_W'(lsm_pkg::GAIN_RST);
		end else if (agc_down && gain_step != '0) begin
			if (mode_first[lsm_pkg::M1_DOUBLE] && agc_sat && gain_step > GAIN_W'(1)) begin
				gain_step <= gain_step - GAIN_W'(2);
			end else begin
				gain_step <= gain_step - GAIN_W'(1);
			end
		end else if (agc_up && !agc_down && gain_step < GAIN_W'(lsm_pkg::GAIN_MAX)) begin
			gain_step <= gain_step + GAIN_W'(1);
		end
	end

	lsm_scale u_scale (
		.raw(ambient_raw),
		.top_sel(mode_second[lsm_pkg::M2_TOP_LSB +: lsm_pkg::TOP_W]),
		.scale_bits(mode_first[lsm_pkg::M1_SCALE_LSB +: lsm_pkg::SCALE_W]),
		.data(scale_data),
		.scaled(scale_flag)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ambient_data <= 16'h0;
			amb_scaled <= 1'b0;
			sum_hold <= 16'h0;
		end else begin
			if (amb_hit) begin
				ambient_data <= scale_data;
				amb_scaled <= scale_flag;
			end
			if (flick_hit) begin
				sum_hold <= flicker_sum;
			end
		end
	end

	// record requests; a new request wins over the clear of a record just sent
	always_comb begin
		rec_set = '0;
		rec_set[lsm_pkg::REC_AMB_DATA] = amb_hit;
		rec_set[lsm_pkg::REC_AMB_STATUS] = amb_hit && mode_first[lsm_pkg::M1_QSTAT];
		rec_set[lsm_pkg::REC_GAIN] = flick_hit && mode_second[lsm_pkg::M2_QGAIN];
		rec_set[lsm_pkg::REC_SUM] = flick_hit && mode_second[lsm_pkg::M2_QSUM];
		rec_set[lsm_pkg::REC_END] = flick_hit && mode_second[lsm_pkg::M2_QEND] && !endless;
	end

	always_comb begin
		cur_kind = 3'(lsm_pkg::REC_KINDS - 1);
		for (int i = lsm_pkg::REC_KINDS - 1; i >= 0; i--) begin
			if (pending[i]) begin
				cur_kind = 3'(i);
			end
		end
		rec_clr = '0;
		if (rec_valid && rec_ready) begin
			rec_clr[cur_kind] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pending <= '0;
		end else begin
			pending <= (pending & ~rec_clr) | rec_set;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			emit_state <= lsm_pkg::EMIT_IDLE;
		end else begin
			case (emit_state)
				lsm_pkg::EMIT_IDLE: begin
					if (rec_set != '0) begin
						emit_state <= lsm_pkg::EMIT_SEND;
					end
				end
				lsm_pkg::EMIT_SEND: begin
					if (((pending & ~rec_clr) | rec_set) == '0) begin
						emit_state <= lsm_pkg::EMIT_IDLE;
					end
				end
				default: begin
					emit_state <= lsm_pkg::EMIT_IDLE;
				end
			endcase
		end
	end

	assign rec_valid = (emit_state == lsm_pkg::EMIT_SEND) && (pending != '0);

	always_comb begin
		rec.kind = lsm_pkg::lsm_rec_kind_t'(cur_kind);
		case (cur_kind)
			3'h0: rec.data = ambient_data;
			3'h1: rec.data = {7'h00, amb_scaled, 3'h0, mode_second[lsm_pkg::M2_TOP_LSB +: lsm_pkg::TOP_W]};
			3'h2: rec.data = 16'(gain_step);
			3'h3: rec.data = sum_hold;
			default: rec.data = 16'h0;
		endcase
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	power_clear_a: assert property (wr_enable && !pwdata[0] |=> !enable[6] && !enable[1] && !osc_enable)
		else $error("power off left a measure enable set");
	osc_gate_a: assert property ((ambient_run || flicker_run) |-> osc_enable)
		else $error("measurement running without oscillator");
	flick_write_a: assert property (wr_enable && pwdata[0] |=> flicker_run == ($past(pwdata[6]) && !sleep_after_irq))
		else $error("flicker enable did not follow write");
	amb_write_a: assert property (wr_enable && pwdata[0] |=> ambient_run == ($past(pwdata[1]) && !sleep_after_irq))
		else $error("ambient enable did not follow write");
	halt_clear_a: assert property (halt_now && !wr_enable |=> !ambient_run && !flicker_run && osc_enable)
		else $error("halt did not stop measurement with power kept");
	double_drop_a: assert property (agc_down && agc_sat && mode_first[6] && gain_step > 1
		|=> gain_step == $past(gain_step) - GAIN_W'(2))
		else $error("saturation did not drop gain by two");
	single_sleep_a: assert property (mode_first[5] && amb_hit |=> sleep_after_irq && !ambient_run)
		else $error("single run did not enter sleep");
	status_queue_a: assert property (amb_hit && mode_first[4] |=> pending[1])
		else $error("ambient status record not queued");
	end_tag_a: assert property (flick_hit && mode_second[7] && !endless |=> pending[4])
		else $error("end record not queued");
	endless_tag_a: assert property ($rose(pending[4]) |-> !$past(endless))
		else $error("end record queued during endless runs");
	reserved_zero_a: assert property ((enable & ~lsm_pkg::ENABLE_MASK) == 8'h00)
		else $error("reserved enable bit stored");
	sum_queue_a: assert property (flick_hit && mode_second[6] |=> pending[3])
		else $error("checksum record not queued");

	halt_seen_c: cover property (halt_now);
	double_seen_c: cover property (agc_down && agc_sat && mode_first[6] && gain_step > 1);
	sleep_seen_c: cover property ($rose(sleep_after_irq));
	record_burst_c: cover property (rec_valid && rec_ready ##1 rec_valid && rec_ready ##1 rec_valid);
endmodule : lsm_measure_ctrl
`default_nettype wire

/* pkg/lsm_pkg.sv */
// shared constants and types for the light sensor measurement control block
package lsm_pkg;
	localparam int ADDR_W = 12;
	// register indexes; byte address is four times the index
	localparam logic [7:0] IDX_ENABLE = 8'h80;
	localparam logic [7:0] IDX_MODE_FIRST = 8'h81;
	localparam logic [7:0] IDX_MODE_SECOND = 8'h82;
	localparam logic [7:0] IDX_RUN_CTRL = 8'h90;
	localparam logic [7:0] IDX_STATUS = 8'h91;
	localparam logic [7:0] IDX_AMB_DATA = 8'h92;
	// power_and_measure_enable fields
	localparam int EN_FLICKER = 6;
	localparam int EN_AMBIENT = 1;
	localparam int EN_POWER = 0;
	localparam logic [7:0] ENABLE_MASK = 8'h43;
	localparam logic [7:0] HALT_KEEP = 8'h01;
	// measure_mode_first fields
	localparam int M1_HALT = 7;
	localparam int M1_DOUBLE = 6;
	localparam int M1_SINGLE = 5;
	localparam int M1_QSTAT = 4;
	localparam int M1_SCALE_LSB = 0;
	localparam int SCALE_W = 4;
	// measure_mode_second fields
	localparam int M2_QEND = 7;
	localparam int M2_QSUM = 6;
	localparam int M2_QGAIN = 5;
	localparam int M2_TOP_LSB = 0;
	localparam int TOP_W = 5;
	// run_control fields
	localparam int RC_ENDLESS = 7;
	localparam int RC_LIMIT_LSB = 0;
	localparam int LIMIT_W = 4;
	// status fields
	localparam int ST_GAIN_LSB = 0;
	localparam int ST_SLEEP = 4;
	localparam int ST_OSC = 5;
	localparam int ST_SCALED = 6;
	// reset values, limits and the record kind count
	localparam logic [7:0] ENABLE_RST = 8'h00;
	localparam logic [7:0] MODE_FIRST_RST = 8'h04;
	localparam logic [7:0] MODE_SECOND_RST = 8'h0c;
	localparam logic [7:0] RUN_CTRL_RST = 8'h00;
	localparam logic [3:0] GAIN_RST = 4'h9;
	localparam logic [3:0] GAIN_MAX = 4'hc;
	localparam logic [4:0] WIN_TOP = 5'h0f;
	localparam int REC_KINDS = 5;

	typedef enum logic [2:0] {
		REC_AMB_DATA = 3'b000,
		REC_AMB_STATUS = 3'b001,
		REC_GAIN = 3'b010,
		REC_SUM = 3'b011,
		REC_END = 3'b100
	} lsm_rec_kind_t;

	typedef struct packed {
		lsm_rec_kind_t kind;
		logic [15:0] data;
	} lsm_rec_t;

	typedef enum logic {
		EMIT_IDLE = 1'b0,
		EMIT_SEND = 1'b1
	} lsm_emit_t;

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction : byte_addr
endpackage : lsm_pkg

/* hdl/lsm_scale.sv */
// reduction of the wide ambient result to the 16-bit data word
`timescale 1ns/1ps
`default_nettype none
module lsm_scale (
	input wire logic [31:0] raw,
	input wire logic [lsm_pkg::TOP_W-1:0] top_sel,
	input wire logic [lsm_pkg::SCALE_W-1:0] scale_bits,
	output logic [15:0] data,
	output logic scaled
);
	logic [4:0] win_shift;
	logic [4:0] fine_shift;
	logic [15:0] window;
	logic [15:0] fine;
	logic [4:0] head_shift;
	logic top_clear;

	always_comb begin
		// top_sel names the bit treated as most significant, from bit 15 up; lower values keep bit 15 on top
		win_shift = (top_sel > lsm_pkg::WIN_TOP) ? top_sel - lsm_pkg::WIN_TOP : 5'h00;
		window = 16'(raw >> win_shift);
		head_shift = 5'(16 - int'(scale_bits));
		// scaled form only when enough leading bits are zero
		top_clear = (scale_bits == 4'h0) || ((32'(window) >> head_shift) == 32'h0);
		fine_shift = (win_shift > 5'(scale_bits)) ? win_shift - 5'(scale_bits) : 5'h00;
		fine = 16'(raw >> fine_shift);
		scaled = top_clear;
		data = top_clear ? fine : window;
	end
endmodule : lsm_scale
`default_nettype wire

/* bench/lsm_engine_model.sv */
// behavioural measurement engine and record sink facing the control block
`timescale 1ns/1ps
`default_nettype none
module lsm_engine_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ambient_run,
	input wire logic flicker_run,
	input wire logic amb_go,
	input wire logic flk_go,
	input wire logic stall,
	input wire logic [31:0] raw_val,
	input wire logic [15:0] sum_val,
	output logic ambient_done,
	output logic flicker_done,
	output logic [31:0] ambient_raw,
	output logic [15:0] flicker_sum,
	output logic rec_ready
);
	logic phase;
	// a cycle only completes while the block keeps that channel running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ambient_done <= 1'b0;
			flicker_done <= 1'b0;
			phase <= 1'b0;
		end else begin
			ambient_done <= amb_go & ambient_run;
			flicker_done <= flk_go & flicker_run;
			phase <= ~phase;
		end
	end
	// results mean nothing outside their done pulse, so show garbage there
	assign ambient_raw = ambient_done ? raw_val : ~raw_val;
	assign flicker_sum = flicker_done ? sum_val : ~sum_val;
	// a stalling sink takes a record only every other cycle
	assign rec_ready = ~stall | phase;
endmodule : lsm_engine_model
`default_nettype wire

/* bench/lsm_measure_ctrl_tb.sv */
// self-checking bench for the measurement control block
`timescale 1ns/1ps
`default_nettype none
module lsm_measure_ctrl_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, raw_val = 32'h0;
	logic [15:0] sum_val = 16'h0;
	logic amb_go = 1'b0, flk_go = 1'b0, stall = 1'b0, agc_down = 1'b0, agc_sat = 1'b0;
	logic pready, pslverr, osc_enable, ambient_run, flicker_run, sleep_after_irq;
	logic ambient_done, flicker_done, rec_valid, rec_ready, e;
	int n_recs = 0;
	int recs_before = 0;
	logic [31:0] prdata, ambient_raw, q;
	logic [15:0] flicker_sum, ambient_data, rdat;
	logic [3:0] gain_step;
	lsm_pkg::lsm_rec_t rec;
	int fails = 0;
	int n_tests = 0;

	always #20 pclk = ~pclk;

	lsm_measure_ctrl #(.GAIN_W(4)) i_lsm_measure_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb(4'h1), .pready, .prdata, .pslverr, .osc_enable, .ambient_run, .flicker_run,
		.sleep_after_irq, .ambient_done, .flicker_done, .ambient_raw, .flicker_sum, .agc_down, .agc_sat,
		.agc_up(1'b0), .gain_step, .ambient_data, .rec_valid, .rec_ready, .rec);

	lsm_engine_model i_lsm_engine_model (.pclk, .presetn, .ambient_run, .flicker_run, .amb_go, .flk_go,
		.stall, .raw_val, .sum_val, .ambient_done, .flicker_done, .ambient_raw, .flicker_sum, .rec_ready);

	always @(posedge pclk) begin
		if (rec_valid === 1'b1) n_recs <= n_recs + 1;
	end

	task automatic chk(input logic [31:0] seen_v, input logic [31:0] exp_v);
		n_tests++;
		if (seen_v !== exp_v) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen_v, exp_v);
		end
	endtask : chk

	// one apb transfer; waits on pready, never on a fixed latency
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [31:0] exp_v);
		apb(1'b0, idx, 8'h00);
		chk(q, exp_v);
	endtask : rd

	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask : tick

	task automatic go(input logic amb);
		@(posedge pclk);
		amb_go <= amb;
		flk_go <= ~amb;
		@(posedge pclk);
		amb_go <= 1'b0;
		flk_go <= 1'b0;
	endtask : go

	task automatic agc_hit();
		@(posedge pclk);
		agc_down <= 1'b1;
		agc_sat <= 1'b1;
		@(posedge pclk);
		agc_down <= 1'b0;
		agc_sat <= 1'b0;
		tick(2);
	endtask : agc_hit

	// waits for the next record handed over and checks its kind
	task automatic getrec(input logic [2:0] kind);
		do begin
			@(posedge pclk);
		end while (!(rec_valid === 1'b1 && rec_ready === 1'b1));
		rdat = rec.data;
		chk({29'h0, rec.kind}, {29'h0, kind});
	endtask : getrec

	task automatic tally_and_finish();
		$display("comparisons %0d, mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (5000) @(posedge pclk);
		fails++;
		tally_and_finish();
	end

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h80, 32'h00);
		rd(8'h81, 32'h04);
		rd(8'h82, 32'h0c);
		wr(8'h81, 8'hff);
		rd(8'h81, 32'hff);
		wr(8'h82, 8'hff);
		rd(8'h82, 32'hff);
		wr(8'h81, 8'h04);
		wr(8'h82, 8'h0c);
		apb(1'b0, 8'hff, 8'h00);
		chk({31'h0, e}, 32'h1);
		chk(q, 32'h0);
		wr(8'h80, 8'hff);
		rd(8'h80, 32'h43);
		chk({31'h0, osc_enable}, 32'h1);
		chk({31'h0, ambient_run}, 32'h1);
		chk({31'h0, flicker_run}, 32'h1);
		wr(8'h80, 8'h41);
		rd(8'h80, 32'h41);
		chk({31'h0, ambient_run}, 32'h0);
		chk({31'h0, flicker_run}, 32'h1);
		wr(8'h80, 8'h42);
		rd(8'h80, 32'h00);
		chk({31'h0, osc_enable}, 32'h0);
		chk({31'h0, ambient_run}, 32'h0);
		wr(8'h80, 8'h01);
		wr(8'h81, 8'h44);
		agc_hit();
		chk({28'h0, gain_step}, 32'h7);
		wr(8'h81, 8'h04);
		agc_hit();
		chk({28'h0, gain_step}, 32'h6);
		// halt with a limit of zero stops after the first completion
		wr(8'h81, 8'h84);
		wr(8'h90, 8'h00);
		wr(8'h80, 8'h03);
		go(1'b1);
		tick(3);
		rd(8'h80, 32'h01);
		chk({31'h0, osc_enable}, 32'h1);
		wr(8'h81, 8'h14);
		raw_val <= 32'h00000123;
		wr(8'h80, 8'h03);
		go(1'b1);
		getrec(3'd0);
		chk({16'h0, rdat}, 32'h0123);
		getrec(3'd1);
		chk({16'h0, ambient_data}, 32'h0123);
		rd(8'h92, 32'h0123);
		// top bit 19 moves the window down by 4; 0xab00 has no leading zeros, so unscaled
		wr(8'h82, 8'h13);
		raw_val <= 32'h000ab000;
		go(1'b1);
		getrec(3'd0);
		chk({16'h0, rdat}, 32'hab00);
		getrec(3'd1);
		wr(8'h81, 8'h04);
		stall <= 1'b1;
		sum_val <= 16'h1234;
		wr(8'h82, 8'hec);
		wr(8'h80, 8'h41);
		go(1'b0);
		getrec(3'd2);
		chk({16'h0, rdat}, 32'h0006);
		getrec(3'd3);
		chk({16'h0, rdat}, 32'h1234);
		getrec(3'd4);
		stall <= 1'b0;
		wr(8'h82, 8'h8c);
		wr(8'h90, 8'h80);
		wr(8'h81, 8'h84);
		wr(8'h80, 8'h41);
		recs_before = n_recs;
		go(1'b0);
		go(1'b0);
		tick(6);
		chk(32'(n_recs - recs_before), 32'h0);
		rd(8'h80, 32'h41);
		wr(8'h90, 8'h00);
		wr(8'h81, 8'h24);
		wr(8'h80, 8'h03);
		go(1'b1);
		tick(3);
		chk({31'h0, sleep_after_irq}, 32'h1);
		chk({31'h0, ambient_run}, 32'h0);
		// status: gain 6, sleep and oscillator set, last ambient unscaled
		rd(8'h91, 32'h36);
		wr(8'h80, 8'h00);
		// a reset after power is cleared must bring enable and both mode registers back to their reset values
		presetn <= 1'b0;
		tick(2);
		presetn <= 1'b1;
		rd(8'h80, 32'h00);
		rd(8'h81, 32'h04);
		rd(8'h82, 32'h0c);
		tally_and_finish();
	end
endmodule : lsm_measure_ctrl_tb
`default_nettype wire
